// file: hdl/svc_lock_pkg.sv
package svc_lock_pkg;

   // Register bus geometry
   localparam int          ADDR_W           = 8;
   localparam int          DATA_W           = 32;
   localparam int          STRB_W           = 4;

   // Register byte offsets
   localparam logic [7:0]  RAW_OFFSET       = 8'h38;
   localparam logic [7:0]  MASK_OFFSET      = 8'h3c;
   localparam logic [7:0]  WIPE_OFFSET      = 8'h40;
   localparam logic [7:0]  FORCE_OFFSET     = 8'h44;
   localparam logic [7:0]  PROT_OFFSET      = 8'h50;

   // Bus responses
   localparam logic [1:0]  RESP_OKAY        = 2'h0;
   localparam logic [1:0]  RESP_SLVERR      = 2'h2;

   // Event bit positions
   localparam int          BIT_WATCHDOG_EARLY_WARNING = 0;
   localparam int          BIT_PERIODIC_TICK          = 1;
   localparam int          BIT_ALARM                  = 2;
   localparam int          BIT_SUPPLY_EARLY_WARNING   = 3;
   localparam int          BIT_SUPPLY_DIP             = 7;
   localparam int          BIT_CLOCK_LOSS             = 16;
   localparam int          BIT_MAIN_RAM_PARITY        = 17;
   localparam int          BIT_SERIAL_RAM_PARITY      = 18;
   localparam int          BIT_FLASH_DOUBLE_ERROR     = 19;
   localparam int          BIT_FLASH_DONE             = 20;
   localparam int          BIT_VOLTAGE_CLAMP          = 21;
   localparam int          BIT_STANDBY_CLOCK_FAIL     = 22;
   localparam int          BIT_TIMEKEEPER_CONTROL_MU  = 24;
   localparam int          BIT_ALARM_WORD0_MU         = 25;
   localparam int          BIT_ALARM_WORD1_MU         = 26;
   localparam int          BIT_TIME_WORD0_MU          = 27;
   localparam int          BIT_TIME_WORD1_MU          = 28;
   localparam int          BIT_TEMP_MEASURE_DONE      = 29;
   localparam int          BIT_TEMP_OVER_LIMIT        = 30;
   localparam int          BIT_TEMP_UNDER_LIMIT       = 31;

   // Implemented event bits: 0..3, 7, 16..22, 24..31
   localparam logic [31:0] EVENT_IMPL_MASK  = 32'hff7f008f;

   // Reset values
   localparam logic [31:0] RAW_RESET        = 32'h00000000;
   localparam logic [31:0] MASK_RESET       = 32'h00000000;
   localparam logic [1:0]  MODE_RESET       = 2'h3;
   localparam logic        LOCK_RESET       = 1'b1;

   // Protection control field layout
   localparam int          MODE_LSB         = 0;
   localparam int          LOCK_STATUS_BIT  = 2;
   localparam int          PASS_LSB         = 3;
   localparam logic [1:0]  MODE_OFF         = 2'h0;

   // Password codes
   localparam logic [4:0]  PASS_MODE_UNLOCK = 5'h18;
   localparam logic [4:0]  PASS_OPEN        = 5'h13;
   localparam logic [4:0]  PASS_CLOSE       = 5'h15;

   typedef struct packed {
      logic [ADDR_W-1:0] awaddr;
      logic              awvalid;
      logic [DATA_W-1:0] wdata;
      logic [STRB_W-1:0] wstrb;
      logic              wvalid;
      logic              bready;
      logic [ADDR_W-1:0] araddr;
      logic              arvalid;
      logic              rready;
   } axil_req_t;

   typedef struct packed {
      logic              awready;
      logic              wready;
      logic [1:0]        bresp;
      logic              bvalid;
      logic              arready;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        rresp;
      logic              rvalid;
   } axil_rsp_t;

   typedef struct packed {
      logic              fire;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [STRB_W-1:0] strb;
   } reg_write_t;

   typedef struct packed {
      logic              aw_done;
      logic              w_done;
      reg_write_t        wr;
      axil_rsp_t         rsp;
   } port_state_t;

   typedef enum logic [1:0] {
      PRIME_IDLE = 2'b01,
      PRIME_WAIT = 2'b10
   } prime_state_t;

   typedef struct packed {
      logic [DATA_W-1:0] mask;
      logic [1:0]        mode;
      logic              lock_flag;
      prime_state_t      prime;
      logic              lock;
      logic              irq;
   } ctrl_state_t;

   function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
      return (addr == RAW_OFFSET) || (addr == MASK_OFFSET) || (addr == WIPE_OFFSET) ||
             (addr == FORCE_OFFSET) || (addr == PROT_OFFSET);
   endfunction : addr_mapped

endpackage : svc_lock_pkg

// file: hdl/axil_reg_port.sv
`timescale 1ns/10ps
module axil_reg_port (
   input  wire logic                    clk_in,
   input  wire logic                    rst_n_in,
   input  wire svc_lock_pkg::axil_req_t axil_in,
   output svc_lock_pkg::axil_rsp_t      axil_out,
   input  wire logic [31:0]             rd_data_in,
   output svc_lock_pkg::reg_write_t     wr_out
);
   import svc_lock_pkg::*;

   port_state_t state_reg;
   port_state_t state_next;
   logic        aw_take;
   logic        w_take;
   logic        ar_take;

   always_comb begin
      state_next         = state_reg;
      state_next.wr.fire = 1'b0;
      aw_take            = axil_in.awvalid & state_reg.rsp.awready;
      w_take             = axil_in.wvalid & state_reg.rsp.wready;
      ar_take            = axil_in.arvalid & state_reg.rsp.arready;
      // Address and data are taken in either order
      if (aw_take) begin
         state_next.wr.addr     = axil_in.awaddr;
         state_next.aw_done     = 1'b1;
         state_next.rsp.awready = 1'b0;
      end
      if (w_take) begin
         state_next.wr.data    = axil_in.wdata;
         state_next.wr.strb    = axil_in.wstrb;
         state_next.w_done     = 1'b1;
         state_next.rsp.wready = 1'b0;
      end
      // Both halves present: issue one write pulse with the response
      if (state_next.aw_done && state_next.w_done && !state_reg.rsp.bvalid) begin
         state_next.wr.fire    = 1'b1;
         state_next.rsp.bvalid = 1'b1;
         state_next.rsp.bresp  = addr_mapped(state_next.wr.addr) ? RESP_OKAY : RESP_SLVERR;
         state_next.aw_done    = 1'b0;
         state_next.w_done     = 1'b0;
      end
      if (state_reg.rsp.bvalid && axil_in.bready) begin
         state_next.rsp.bvalid  = 1'b0;
         state_next.rsp.awready = 1'b1;
         state_next.rsp.wready  = 1'b1;
      end
      // Read data is captured on the address handshake
      if (ar_take) begin
         state_next.rsp.rvalid  = 1'b1;
         state_next.rsp.rdata   = rd_data_in;
         state_next.rsp.rresp   = addr_mapped(axil_in.araddr) ? RESP_OKAY : RESP_SLVERR;
         state_next.rsp.arready = 1'b0;
      end else if (state_reg.rsp.rvalid && axil_in.rready) begin
         state_next.rsp.rvalid  = 1'b0;
         state_next.rsp.arready = 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg             <= '0;
         state_reg.rsp.awready <= 1'b1;
         state_reg.rsp.wready  <= 1'b1;
         state_reg.rsp.arready <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   assign axil_out = state_reg.rsp;
   assign wr_out   = state_reg.wr;

endmodule : axil_reg_port

// file: hdl/raw_event_bank.sv
`timescale 1ns/10ps
module raw_event_bank #(
   parameter int           WIDTH = 32,
   parameter logic [31:0]  IMPL  = 32'hffffffff
) (
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic [WIDTH-1:0] event_in,
   input  wire logic [WIDTH-1:0] force_in,
   input  wire logic [WIDTH-1:0] wipe_in,
   output logic      [WIDTH-1:0] raw_out
);
   import svc_lock_pkg::*;

   logic [WIDTH-1:0] raw_reg;
   logic [WIDTH-1:0] raw_next;

   // Set by event or force wins over a wipe in the same cycle
   always_comb begin
      raw_next = ((raw_reg & ~wipe_in) | force_in | event_in) & IMPL[WIDTH-1:0];
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         raw_reg <= RAW_RESET[WIDTH-1:0];
      end else begin
         raw_reg <= raw_next;
      end
   end

   assign raw_out = raw_reg;

endmodule : raw_event_bank

// file: hdl/service_request_set_and_write_lock.sv
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/10ps
// Summary of operation
// - Force write of one sets raw status bit
// - Bits 0-3 and 7: watchdog, timekeeping, supply
// - Bits 16-22: clock, parity, flash, clamp, standby
// - Bits 24-28: timekeeper mirror update events
// - Bits 29-31: temperature sensor events
// - Mode 00 disables the protection scheme
// - Mode 11 default enables password protection
// - Other nonzero modes behave like 11
// - Mode changes only after password 11000
// - Lock status bit 2 shows write blocking
// - Password 10011 opens protected bit writes
// - Password 10101 closes protected bit writes
// - Unknown passwords change nothing, except that a primed write still loads the mode
// - Wipe register clears raw bits, ones only
module service_request_set_and_write_lock (
   input  wire logic                    clk_in,
   input  wire logic                    rst_n_in,
   input  wire svc_lock_pkg::axil_req_t axil_in,
   output svc_lock_pkg::axil_rsp_t      axil_out,
   input  wire logic [31:0]             hw_event_in,
   output logic      [31:0]             raw_status_out,
   output logic                         lock_out,
   output logic                         irq_out
);
   import svc_lock_pkg::*;

   ctrl_state_t state_reg;
   ctrl_state_t state_next;
   reg_write_t  wr;
   logic [31:0] byte_en;
   logic [31:0] wr_data;
   logic [31:0] force_vec;
   logic [31:0] wipe_vec;
   logic [31:0] rd_data;
   logic [31:0] raw;
   logic [4:0]  pass_code;

   axil_reg_port u_port (
      .clk_in     (clk_in),
      .rst_n_in   (rst_n_in),
      .axil_in    (axil_in),
      .axil_out   (axil_out),
      .rd_data_in (rd_data),
      .wr_out     (wr)
   );

   raw_event_bank #(
      .WIDTH (32),
      .IMPL  (EVENT_IMPL_MASK)
   ) u_raw (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .event_in (hw_event_in),
      .force_in (force_vec),
      .wipe_in  (wipe_vec),
      .raw_out  (raw)
   );

   always_comb begin
      state_next = state_reg;
      force_vec  = 32'h00000000;
      wipe_vec   = 32'h00000000;
      byte_en    = {{8{wr.strb[3]}}, {8{wr.strb[2]}}, {8{wr.strb[1]}}, {8{wr.strb[0]}}};
      wr_data    = wr.data & byte_en;
      pass_code  = wr.data[PASS_LSB +: 5];
      if (wr.fire) begin
         if (wr.addr == FORCE_OFFSET) begin
            force_vec = wr_data & EVENT_IMPL_MASK;
         end else if (wr.addr == WIPE_OFFSET || wr.addr == RAW_OFFSET) begin
            wipe_vec = wr_data & EVENT_IMPL_MASK;
         end else if (wr.addr == MASK_OFFSET) begin
            state_next.mask = ((state_reg.mask & ~byte_en) | wr_data) & EVENT_IMPL_MASK;
         end else if (wr.addr == PROT_OFFSET && wr.strb[0]) begin
            // Primed write registers the new mode field
            if (state_reg.prime == PRIME_WAIT) begin
               state_next.mode  = wr.data[MODE_LSB +: 2];
               state_next.prime = PRIME_IDLE;
            end
            if (pass_code == PASS_MODE_UNLOCK) begin
               state_next.prime = PRIME_WAIT;
            end else if (pass_code == PASS_OPEN) begin
               state_next.lock_flag = 1'b0;
            end else if (pass_code == PASS_CLOSE) begin
               state_next.lock_flag = 1'b1;
            end
            // Any other code leaves access untouched; mode changes only on a primed write
         end
      end
      // Mode 00 opens all bits; any other mode follows the password state
      state_next.lock = (state_next.mode != MODE_OFF) & state_next.lock_flag;
      state_next.irq  = |(raw & state_reg.mask);
   end

   // Read data selection; unmapped and write-only locations read zero
   always_comb begin
      rd_data = 32'h00000000;
      if (axil_in.araddr == RAW_OFFSET) begin
         rd_data = raw;
      end else if (axil_in.araddr == MASK_OFFSET) begin
         rd_data = state_reg.mask;
      end else if (axil_in.araddr == PROT_OFFSET) begin
         rd_data[MODE_LSB +: 2]   = state_reg.mode;
         rd_data[LOCK_STATUS_BIT] = state_reg.lock;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg.mask      <= MASK_RESET;
         state_reg.mode      <= MODE_RESET;
         state_reg.lock_flag <= LOCK_RESET;
         state_reg.prime     <= PRIME_IDLE;
         state_reg.lock      <= LOCK_RESET;
         state_reg.irq       <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign raw_status_out = raw;
   assign lock_out       = state_reg.lock;
   assign irq_out        = state_reg.irq;

endmodule : service_request_set_and_write_lock

// file: tb/service_request_set_and_write_lock_sva.sv
`timescale 1ns/10ps
module service_request_set_and_write_lock_sva (
   input wire logic                    clk_in,
   input wire logic                    rst_n_in,
   input wire svc_lock_pkg::axil_req_t axil_in,
   input wire svc_lock_pkg::axil_rsp_t axil_out,
   input wire logic [31:0]             hw_event_in,
   input wire logic [31:0]             raw_status_out,
   input wire logic                    lock_out,
   input wire logic                    irq_out
);
   import svc_lock_pkg::*;
   logic [7:0] ra_reg;
   logic       rp;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) ra_reg <= '0;
      else if (axil_in.arvalid && axil_out.arready) ra_reg <= axil_in.araddr;
   end
   assign rp = axil_out.rvalid && (ra_reg == PROT_OFFSET);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   a_raw_set_cause: assert property ((raw_status_out & ~$past(raw_status_out)) != 0 |->
      $past(axil_out.bvalid) || $past(hw_event_in) != 0 || $past(hw_event_in, 2) != 0)
      else $error("raw bit set without cause");
   a_raw_clr_cause: assert property (($past(raw_status_out) & ~raw_status_out) != 0 |->
      $past(axil_out.bvalid)) else $error("raw bit cleared without write");
   a_raw_impl_only: assert property ((raw_status_out & ~EVENT_IMPL_MASK) == '0)
      else $error("unimplemented raw bit set");
   a_wo_reads_zero: assert property (axil_out.rvalid && (ra_reg == FORCE_OFFSET ||
      ra_reg == WIPE_OFFSET) |-> axil_out.rdata == '0) else $error("write-only read not zero");
   a_prot_pad_zero: assert property (rp |-> axil_out.rdata[31:3] == '0)
      else $error("protection upper bits not zero");
   a_status_lock: assert property (rp |-> axil_out.rdata[2] == lock_out)
      else $error("lock status differs from lock output");
   a_mode_off_open: assert property (rp && axil_out.rdata[1:0] == MODE_OFF |->
      !axil_out.rdata[2]) else $error("mode off but locked");
   a_open_cause: assert property ($fell(lock_out) |-> $past(axil_out.bvalid))
      else $error("lock opened without write");
   a_close_cause: assert property ($rose(lock_out) |-> $past(axil_out.bvalid))
      else $error("lock closed without write");
endmodule : service_request_set_and_write_lock_sva
bind service_request_set_and_write_lock service_request_set_and_write_lock_sva u_sva (
   .clk_in(clk_in), .rst_n_in(rst_n_in), .axil_in(axil_in), .axil_out(axil_out),
   .hw_event_in(hw_event_in), .raw_status_out(raw_status_out), .lock_out(lock_out),
   .irq_out(irq_out));

// file: tb/service_request_set_and_write_lock_test.sv
`timescale 1ns/10ps
module service_request_set_and_write_lock_test;
   import svc_lock_pkg::*;
   logic        clk_in = 1'b0;
   logic        rst_n_in = 1'b0;
   axil_req_t   req = '0;
   axil_rsp_t   rsp;
   logic [31:0] hw_ev = '0;
   logic [31:0] raw;
   logic        lock;
   logic        irq;
   logic [31:0] d;
   logic [1:0]  r;
   logic [1:0]  pm;
   int          num_errors = 0;
   int          n_checks = 0;
   int          cyc = 0;
   always #5 clk_in = ~clk_in;
   service_request_set_and_write_lock u_service_request_set_and_write_lock (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .axil_in(req), .axil_out(rsp),
      .hw_event_in(hw_ev), .raw_status_out(raw), .lock_out(lock), .irq_out(irq));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic done;
      done = 1'b0;
      @(posedge clk_in);
      req.awaddr <= a;
      req.awvalid <= 1'b1;
      req.wdata <= v;
      req.wstrb <= 4'hf;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      while (!done) begin
         @(posedge clk_in);
         if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
         if (rsp.bvalid === 1'b1) begin
            r = rsp.bresp;
            req.bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask : wr
   task automatic rd(input logic [7:0] a);
      logic done;
      done = 1'b0;
      @(posedge clk_in);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      while (!done) begin
         @(posedge clk_in);
         if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
         if (rsp.rvalid === 1'b1) begin
            d = rsp.rdata;
            r = rsp.rresp;
            req.rready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask : rd
   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(n, e, d);
   endtask : rchk
   task automatic results();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : results
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         results();
      end
   end
   initial begin
      repeat (20) @(posedge clk_in);
      rst_n_in <= 1'b1;
      chk("lock_out", 32'h1, {31'h0, lock});
      rchk("prot", PROT_OFFSET, 32'h7);
      chk("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
      $display("test reset done");
      for (int i = 0; i < 32; i++) begin
         wr(FORCE_OFFSET, 32'h1 << i);
         chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
         rchk("raw", RAW_OFFSET, EVENT_IMPL_MASK & (32'h1 << i));
         wr(FORCE_OFFSET, 32'h0);
         rchk("raw", RAW_OFFSET, EVENT_IMPL_MASK & (32'h1 << i));
         rchk("force", FORCE_OFFSET, 32'h0);
         wr(WIPE_OFFSET, 32'h1 << i);
         rchk("raw", RAW_OFFSET, 32'h0);
      end
      $display("test force done");
      wr(PROT_OFFSET, 32'hf8);
      rchk("prot", PROT_OFFSET, 32'h7);
      wr(PROT_OFFSET, 32'h0);
      rchk("prot", PROT_OFFSET, 32'h7);
      wr(PROT_OFFSET, {24'h0, PASS_OPEN, 3'h0});
      rchk("prot", PROT_OFFSET, 32'h3);
      chk("lock_out", 32'h0, {31'h0, lock});
      wr(PROT_OFFSET, {24'h0, PASS_CLOSE, 3'h0});
      rchk("prot", PROT_OFFSET, 32'h7);
      pm = 2'h3;
      for (int m = 0; m < 4; m++) begin
         wr(PROT_OFFSET, {24'h0, PASS_MODE_UNLOCK, 3'(m)});
         rchk("prot", PROT_OFFSET, {29'h0, pm != 2'h0, pm});
         wr(PROT_OFFSET, {30'h0, 2'(m)});
         rchk("prot", PROT_OFFSET, {29'h0, m != 0, 2'(m)});
         chk("lock_out", {31'h0, m != 0}, {31'h0, lock});
         pm = 2'(m);
      end
      $display("test protection done");
      wr(8'h60, 32'hffffffff);
      chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
      rchk("unmapped", 8'h60, 32'h0);
      chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
      $display("test unmapped done");
      wr(MASK_OFFSET, 32'hffffffff);
      rchk("mask", MASK_OFFSET, EVENT_IMPL_MASK);
      wr(MASK_OFFSET, 32'h1 << BIT_CLOCK_LOSS);
      hw_ev <= 32'h1 << BIT_CLOCK_LOSS;
      @(posedge clk_in);
      hw_ev <= 32'h0;
      repeat (3) @(posedge clk_in);
      chk("raw_port", 32'h1 << BIT_CLOCK_LOSS, raw);
      chk("irq", 32'h1, {31'h0, irq});
      wr(MASK_OFFSET, 32'h0);
      repeat (2) @(posedge clk_in);
      chk("irq", 32'h0, {31'h0, irq});
      wr(MASK_OFFSET, 32'h1 << BIT_CLOCK_LOSS);
      wr(WIPE_OFFSET, 32'h1 << BIT_CLOCK_LOSS);
      repeat (2) @(posedge clk_in);
      chk("irq", 32'h0, {31'h0, irq});
      rchk("raw", RAW_OFFSET, 32'h0);
      $display("test interrupt done");
      results();
   end
endmodule : service_request_set_and_write_lock_test
